// ---- rtl/ghu_host_uart.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - one full duplex port, separate paths
// - eight data bits, no parity, one stop
// - least significant data bit sent first
// - sentences out, host commands in
// - standby command puts module in standby
// - any received byte wakes from standby
// - periodic mode alternates run and sleep
// - adaptive mode picks own interval lengths
// - logger record holds fix and checksum
// - orbit prediction usable three days ahead
// - link runs at 38400 bits per second
// - sentences start dollar, end CR LF, checksummed
module ghu_host_uart #(
  // bit timer from default line rate
  parameter int BIT_CYCLES = ghu_pkg::BIT_CYC,
  parameter int MS_CYCLES = ghu_pkg::MS_CYC,
  parameter logic [31:0] ASSIST_LIMIT_MS = 32'(ghu_pkg::ASSIST_MS)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_in_line,
  output logic serial_out_line,
  input wire logic [7:0] nav_data,
  input wire logic nav_valid,
  output logic nav_ready,
  input wire logic [1:0] motion_level,
  input wire ghu_pkg::ghu_fix_s fix_in,
  input wire logic fix_strobe,
  input wire logic orbit_predicted,
  input wire logic sat_data_poor,
  output ghu_pkg::ghu_mode_e power_mode,
  output logic low_power,
  output logic [7:0] rx_data,
  output logic rx_strobe,
  output logic frame_error,
  output ghu_pkg::ghu_log_s log_record,
  output logic log_write,
  output logic use_assist
);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  // ascii hex digit to nibble
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    hex_val = (c >= 8'h41) ? 4'(c[3:0] + 4'h9) : c[3:0];
  endfunction

  // ----------------------------------------------------------
  // ms tick divider
  // ----------------------------------------------------------
  logic [17:0] ms_cnt_reg, ms_cnt_next; // cycles within a ms
  logic ms_tick; // one-cycle ms enable
  always_comb begin
    ms_tick = (ms_cnt_reg == 18'(MS_CYCLES - 1));
    ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + 1'b1;
  end

  // ----------------------------------------------------------
  // receiver
  // ----------------------------------------------------------
  logic rx_busy_reg, rx_busy_next; // frame in progress
  logic [15:0] rx_cnt_reg, rx_cnt_next; // bit timer
  logic [3:0] rx_bit_reg, rx_bit_next; // bit index, 0 is start
  logic [7:0] rx_sh_reg, rx_sh_next; // shift register
  logic [7:0] rx_data_next; // captured byte
  logic rx_stb_next, ferr_next; // one-cycle results
  logic rx_done; // any byte finished, good or bad
  always_comb begin
    rx_busy_next = rx_busy_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_data_next = rx_data;
    rx_stb_next = 1'b0;
    ferr_next = 1'b0;
    rx_done = 1'b0;
    if (!rx_busy_reg) begin
      // low start bit, first sample half a bit in
      if (serial_in_line == ghu_pkg::LINE_START) begin
        rx_busy_next = 1'b1;
        rx_cnt_next = 16'(BIT_CYCLES / 2);
        rx_bit_next = '0;
      end
    end else if (rx_cnt_reg != '0) begin
      rx_cnt_next = rx_cnt_reg - 1'b1;
    end else begin
      rx_cnt_next = 16'(BIT_CYCLES - 1);
      rx_bit_next = rx_bit_reg + 1'b1;
      if (rx_bit_reg == '0) begin
        // false start: line back high at centre
        if (serial_in_line != ghu_pkg::LINE_START) begin
          rx_busy_next = 1'b0;
        end
      end else if (rx_bit_reg <= 4'(ghu_pkg::DATA_BITS)) begin
        // first data bit lands in bit 0
        rx_sh_next = {serial_in_line, rx_sh_reg[7:1]};
      end else begin
        rx_busy_next = 1'b0;
        rx_done = 1'b1;
        // low stop bit flags and drops the byte
        if (serial_in_line == ghu_pkg::LINE_IDLE) begin
          rx_data_next = rx_sh_reg;
          rx_stb_next = 1'b1;
        end else begin
          ferr_next = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // command sentence parser
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    P_IDLE, P_CMD, P_BODY, P_SUM_HI, P_SUM_LO, P_CR, P_LF
  } ghu_parse_e;
  ghu_parse_e ps_reg, ps_next; // parser state
  logic [7:0] xs_reg, xs_next; // running xor of body
  logic [7:0] cmd_reg, cmd_next; // command letter
  logic [3:0] hi_reg, hi_next; // upper checksum nibble
  logic sum_ok_reg, sum_ok_next; // checksum matched
  logic cmd_fire; // whole sentence accepted
  always_comb begin
    ps_next = ps_reg;
    xs_next = xs_reg;
    cmd_next = cmd_reg;
    hi_next = hi_reg;
    sum_ok_next = sum_ok_reg;
    cmd_fire = 1'b0;
    if (rx_stb_next) begin
      if (rx_data_next == ghu_pkg::CH_DOLLAR) begin
        ps_next = P_CMD;
        xs_next = '0;
      end else begin
        case (ps_reg)
          P_CMD: begin
            cmd_next = rx_data_next;
            xs_next = rx_data_next;
            ps_next = P_BODY;
          end
          P_BODY: begin
            if (rx_data_next == ghu_pkg::CH_STAR) begin
              ps_next = P_SUM_HI;
            end else begin
              xs_next = xs_reg ^ rx_data_next;
            end
          end
          P_SUM_HI: begin
            hi_next = hex_val(rx_data_next);
            ps_next = P_SUM_LO;
          end
          P_SUM_LO: begin
            sum_ok_next = ({hi_reg, hex_val(rx_data_next)} == xs_reg);
            ps_next = P_CR;
          end
          P_CR: begin
            ps_next = (rx_data_next == ghu_pkg::CH_CR) ? P_LF : P_IDLE;
          end
          P_LF: begin
            // accept only after CR LF with good checksum
            cmd_fire = (rx_data_next == ghu_pkg::CH_LF) && sum_ok_reg;
            ps_next = P_IDLE;
          end
          default: begin
            ps_next = P_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // power mode control
  // ----------------------------------------------------------
  ghu_pkg::ghu_mode_e mode_reg, mode_next; // current power mode
  logic asleep_reg, asleep_next; // sleep phase of cycling modes
  logic [31:0] ivl_reg, ivl_next; // ms left in this phase
  always_comb begin
    mode_next = mode_reg;
    asleep_next = asleep_reg;
    ivl_next = ivl_reg;
    if (cmd_fire) begin
      asleep_next = 1'b0;
      case (cmd_reg)
        ghu_pkg::CMD_STANDBY: mode_next = ghu_pkg::MODE_STANDBY;
        ghu_pkg::CMD_PERIODIC: begin
          mode_next = ghu_pkg::MODE_PERIODIC;
          ivl_next = ghu_pkg::PER_RUN_MS;
        end
        ghu_pkg::CMD_ADAPTIVE: begin
          mode_next = ghu_pkg::MODE_ADAPTIVE;
          ivl_next = ghu_pkg::ADP_RUN_MS << motion_level;
        end
        ghu_pkg::CMD_NORMAL: mode_next = ghu_pkg::MODE_NORMAL;
        default: mode_next = mode_reg;
      endcase
    end else if (mode_reg == ghu_pkg::MODE_STANDBY) begin
      // any finished byte wakes, even a bad one
      if (rx_done) begin
        mode_next = ghu_pkg::MODE_NORMAL;
      end
    end else if (mode_reg != ghu_pkg::MODE_NORMAL && ms_tick) begin
      if (ivl_reg > 32'h1) begin
        ivl_next = ivl_reg - 1'b1;
      end else begin
        // swap run and sleep until told otherwise
        asleep_next = !asleep_reg;
        if (mode_reg == ghu_pkg::MODE_PERIODIC) begin
          ivl_next = asleep_reg ? ghu_pkg::PER_RUN_MS : ghu_pkg::PER_SLEEP_MS;
        end else begin
          // more motion, shorter sleep and longer run
          ivl_next = asleep_reg ? ghu_pkg::ADP_RUN_MS << motion_level
                                : ghu_pkg::ADP_SLEEP_MS >> motion_level;
        end
      end
    end
  end

  // ----------------------------------------------------------
  // transmit buffer and transmitter
  // ----------------------------------------------------------
  logic [7:0] tf_data; // byte at buffer head
  logic tf_valid, tf_ready; // buffer head handshake
  ghu_fifo #(.WIDTH(8), .DEPTH(ghu_pkg::FIFO_DEPTH)) u_txq (
    .clk(clk),
    .arst_n(arst_n),
    .in_data(nav_data),
    .in_valid(nav_valid),
    .in_ready(nav_ready),
    .out_data(tf_data),
    .out_valid(tf_valid),
    .out_ready(tf_ready)
  );

  logic tx_busy_reg, tx_busy_next; // frame on the line
  logic [15:0] tx_cnt_reg, tx_cnt_next; // bit timer
  logic [3:0] tx_bit_reg, tx_bit_next; // bits left in frame
  logic [9:0] tx_sh_reg, tx_sh_next; // stop, data, start
  always_comb begin
    tx_busy_next = tx_busy_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    // transmit runs independent of receive; held while asleep
    tf_ready = !tx_busy_reg && !low_power;
    if (tf_ready && tf_valid) begin
      tx_busy_next = 1'b1;
      tx_sh_next = {ghu_pkg::LINE_IDLE, tf_data, ghu_pkg::LINE_START};
      tx_bit_next = 4'(ghu_pkg::DATA_BITS + ghu_pkg::STOP_BITS + 1);
      tx_cnt_next = 16'(BIT_CYCLES - 1);
    end else if (tx_busy_reg) begin
      if (tx_cnt_reg != '0) begin
        tx_cnt_next = tx_cnt_reg - 1'b1;
      end else begin
        // shift right so bit 0 leaves first
        tx_sh_next = {ghu_pkg::LINE_IDLE, tx_sh_reg[9:1]};
        tx_bit_next = tx_bit_reg - 1'b1;
        tx_cnt_next = 16'(BIT_CYCLES - 1);
        tx_busy_next = (tx_bit_reg != 4'h1);
      end
    end
  end

  // ----------------------------------------------------------
  // logger record and orbit assist age
  // ----------------------------------------------------------
  ghu_pkg::ghu_log_s log_next; // record being built
  logic [31:0] age_reg, age_next; // ms since prediction
  logic pred_ok_reg, pred_ok_next; // prediction held
  always_comb begin
    // record is fix plus xor of its bytes
    log_next = log_record;
    if (fix_strobe) begin
      log_next.fix = fix_in;
      log_next.csum = fix_in.utc[31:24] ^ fix_in.utc[23:16] ^ fix_in.utc[15:8]
        ^ fix_in.utc[7:0] ^ fix_in.lat[31:24] ^ fix_in.lat[23:16]
        ^ fix_in.lat[15:8] ^ fix_in.lat[7:0] ^ fix_in.lon[31:24]
        ^ fix_in.lon[23:16] ^ fix_in.lon[15:8] ^ fix_in.lon[7:0]
        ^ {7'h00, fix_in.valid};
    end
    age_next = age_reg;
    pred_ok_next = pred_ok_reg;
    if (orbit_predicted) begin
      age_next = '0;
      pred_ok_next = 1'b1;
    end else if (pred_ok_reg && ms_tick) begin
      age_next = age_reg + 1'b1;
      pred_ok_next = (age_reg + 1'b1 < ASSIST_LIMIT_MS);
    end
  end
  assign use_assist = pred_ok_reg && sat_data_poor;

  // ----------------------------------------------------------
  // outputs from state
  // ----------------------------------------------------------
  assign power_mode = mode_reg;
  assign low_power = (mode_reg == ghu_pkg::MODE_STANDBY) || asleep_reg;
  assign serial_out_line = tx_sh_reg[0];

  // ----------------------------------------------------------
  // all state registers
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_reg <= '0;
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
      rx_data <= '0;
      rx_strobe <= 1'b0;
      frame_error <= 1'b0;
      ps_reg <= P_IDLE;
      xs_reg <= '0;
      cmd_reg <= '0;
      hi_reg <= '0;
      sum_ok_reg <= 1'b0;
      mode_reg <= ghu_pkg::MODE_NORMAL;
      asleep_reg <= 1'b0;
      ivl_reg <= '0;
      tx_busy_reg <= 1'b0;
      tx_cnt_reg <= '0;
      tx_bit_reg <= '0;
      tx_sh_reg <= '1;
      log_record <= '0;
      log_write <= 1'b0;
      age_reg <= '0;
      pred_ok_reg <= 1'b0;
    end else begin
      ms_cnt_reg <= ms_cnt_next;
      rx_busy_reg <= rx_busy_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rx_data <= rx_data_next;
      rx_strobe <= rx_stb_next;
      frame_error <= ferr_next;
      ps_reg <= ps_next;
      xs_reg <= xs_next;
      cmd_reg <= cmd_next;
      hi_reg <= hi_next;
      sum_ok_reg <= sum_ok_next;
      mode_reg <= mode_next;
      asleep_reg <= asleep_next;
      ivl_reg <= ivl_next;
      tx_busy_reg <= tx_busy_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      log_record <= log_next;
      log_write <= fix_strobe;
      age_reg <= age_next;
      pred_ok_reg <= pred_ok_next;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/ghu_pkg.sv ----
// ------------------------------------------------------------
// shared constants and types for the host serial port
// ------------------------------------------------------------
package ghu_pkg;

  // ----------------------------------------------------------
  // clock and link timing
  // ----------------------------------------------------------
  localparam int CLK_HZ = 250_000_000; // core clock rate
  localparam int CLK_PERIOD_NS = 4; // core clock period
  localparam int LINK_BPS = 38400; // default line rate
  localparam int BIT_CYC = CLK_HZ / LINK_BPS; // cycles per bit, rounded down
  localparam int MS_NS = 1_000_000; // one millisecond in ns
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS; // cycles per ms tick
  localparam int ASSIST_DAYS = 3; // prediction horizon in days
  localparam int MS_PER_DAY = 86_400_000; // ms in one day
  localparam int ASSIST_MS = ASSIST_DAYS * MS_PER_DAY; // horizon in ms

  // ----------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------
  localparam int DATA_BITS = 8; // data bits per frame
  localparam int STOP_BITS = 1; // stop bits per frame
  localparam logic LINE_IDLE = 1'h1; // idle and stop level
  localparam logic LINE_START = 1'h0; // start bit level
  localparam int FIFO_DEPTH = 16; // transmit buffer depth

  // ----------------------------------------------------------
  // sentence characters and command letters
  // ----------------------------------------------------------
  localparam logic [7:0] CH_DOLLAR = 8'h24; // sentence start
  localparam logic [7:0] CH_STAR = 8'h2a; // checksum marker
  localparam logic [7:0] CH_CR = 8'h0d; // carriage return
  localparam logic [7:0] CH_LF = 8'h0a; // line feed
  localparam logic [7:0] CMD_NORMAL = 8'h4e; // 'N' full power
  localparam logic [7:0] CMD_STANDBY = 8'h53; // 'S' standby
  localparam logic [7:0] CMD_PERIODIC = 8'h50; // 'P' periodic
  localparam logic [7:0] CMD_ADAPTIVE = 8'h41; // 'A' adaptive periodic

  // ----------------------------------------------------------
  // default interval lengths in ms
  // ----------------------------------------------------------
  localparam logic [31:0] PER_RUN_MS = 32'h0000_03e8; // periodic run time
  localparam logic [31:0] PER_SLEEP_MS = 32'h0000_0fa0; // periodic sleep time
  localparam logic [31:0] ADP_RUN_MS = 32'h0000_01f4; // adaptive base run
  localparam logic [31:0] ADP_SLEEP_MS = 32'h0000_2710; // adaptive base sleep

  // power modes
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_STANDBY,
    MODE_PERIODIC,
    MODE_ADAPTIVE
  } ghu_mode_e;

  // navigation fix handed to the logger
  typedef struct packed {
    logic [31:0] utc;
    logic [31:0] lat;
    logic [31:0] lon;
    logic valid;
  } ghu_fix_s;

  // one stored logger record
  typedef struct packed {
    ghu_fix_s fix;
    logic [7:0] csum;
  } ghu_log_s;

endpackage

// ---- rtl/ghu_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// small fifo with registered output stage
// ------------------------------------------------------------
module ghu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // storage words
  logic [AW-1:0] wr_reg, wr_next; // write pointer
  logic [AW-1:0] rd_reg, rd_next; // read pointer
  logic [AW:0] cnt_reg, cnt_next; // words held in storage
  logic [WIDTH-1:0] dout_reg, dout_next; // output word
  logic ov_reg, ov_next; // output word valid
  logic push, pop; // storage strobes

  assign in_ready = (cnt_reg < (AW+1)'(DEPTH));
  assign out_data = dout_reg;
  assign out_valid = ov_reg;

  // next pointer, count and output stage
  always_comb begin
    push = in_valid && in_ready;
    pop = (cnt_reg != '0) && (!ov_reg || out_ready);
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    dout_next = pop ? mem[rd_reg] : dout_reg;
    ov_next = pop ? 1'b1 : (out_ready ? 1'b0 : ov_reg);
  end

  // register state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      dout_reg <= '0;
      ov_reg <= 1'b0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      dout_reg <= dout_next;
      ov_reg <= ov_next;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

endmodule
`default_nettype wire

// ---- bench/ghu_host_uart_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// port checker for the host serial port
// ------------------------------------------------------------
module ghu_host_uart_asserts #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_out_line,
  input wire ghu_pkg::ghu_fix_s fix_in,
  input wire logic fix_strobe,
  input wire logic sat_data_poor,
  input wire ghu_pkg::ghu_mode_e power_mode,
  input wire logic low_power,
  input wire logic [7:0] rx_data,
  input wire logic rx_strobe,
  input wire logic frame_error,
  input wire ghu_pkg::ghu_log_s log_record,
  input wire logic log_write,
  input wire logic use_assist
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  int tx_cnt_reg, tx_cnt_next; // cycles since start bit, 0 when idle
  logic line_prev_reg; // line level one cycle back

  // frame position follows the transmit line
  always_comb begin
    tx_cnt_next = tx_cnt_reg;
    if (tx_cnt_reg != 0) begin
      tx_cnt_next = (tx_cnt_reg == 10 * BIT_CYCLES - 1) ? 0 : tx_cnt_reg + 1;
    end else if (line_prev_reg && !serial_out_line) begin
      tx_cnt_next = 1;
    end
  end

  // register the frame position
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_cnt_reg <= 0;
      line_prev_reg <= 1'h1;
    end else begin
      tx_cnt_reg <= tx_cnt_next;
      line_prev_reg <= serial_out_line;
    end
  end

  // ----------------------------------------------------------
  // logger steps and port checks
  // ----------------------------------------------------------
  sequence s_fix_taken;
    fix_strobe;
  endsequence
  sequence s_fix_logged;
    log_write && (log_record.fix == $past(fix_in));
  endsequence

  a_log_follows_fix: assert property (s_fix_taken |=> s_fix_logged)
    else $error("log record missing after fix strobe");
  a_log_has_cause: assert property (log_write |-> $past(fix_strobe))
    else $error("log write without fix strobe");
  a_rx_one_result: assert property (!(rx_strobe && frame_error))
    else $error("good byte and framing error together");
  a_rx_pulse_short: assert property ((rx_strobe || frame_error) |=>
    !(rx_strobe || frame_error) [*8])
    else $error("receive result pulses too close");
  a_data_needs_good: assert property ($changed(rx_data) |-> rx_strobe)
    else $error("receive data changed without good byte");
  a_assist_needs_poor: assert property (use_assist |-> sat_data_poor)
    else $error("assist used with good satellite data");
  a_tx_bit_timing: assert property ((tx_cnt_reg != 0 && $changed(serial_out_line))
    |-> (tx_cnt_reg % BIT_CYCLES == 0))
    else $error("transmit line changed inside a bit");
  a_tx_stop_high: assert property ((tx_cnt_reg >= 9 * BIT_CYCLES) |-> serial_out_line)
    else $error("stop bit not high");
  a_standby_low_pwr: assert property ((power_mode == ghu_pkg::MODE_STANDBY) |-> low_power)
    else $error("standby without low power");
  a_normal_full_pwr: assert property ((power_mode == ghu_pkg::MODE_NORMAL) |-> !low_power)
    else $error("normal mode in low power");
  a_mode_by_serial: assert property ($changed(power_mode) |->
    (rx_strobe || frame_error))
    else $error("mode changed without received byte");
  a_wake_any_byte: assert property ((power_mode == ghu_pkg::MODE_STANDBY) ##1
    (rx_strobe || frame_error) |-> power_mode == ghu_pkg::MODE_NORMAL)
    else $error("byte did not wake standby");
endmodule

bind ghu_host_uart ghu_host_uart_asserts #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
  .clk(clk), .arst_n(arst_n), .serial_out_line(serial_out_line),
  .fix_in(fix_in), .fix_strobe(fix_strobe), .sat_data_poor(sat_data_poor),
  .power_mode(power_mode), .low_power(low_power), .rx_data(rx_data),
  .rx_strobe(rx_strobe), .frame_error(frame_error), .log_record(log_record),
  .log_write(log_write), .use_assist(use_assist));
`default_nettype wire

// ---- bench/ghu_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// host processor model on the far side of the serial link
// ------------------------------------------------------------
module ghu_host_model #(
  parameter int BIT = 16
) (
  input wire logic clk,
  output logic to_dev,
  input wire logic from_dev
);
  logic [7:0] got_q[$]; // sentence bytes seen from the module
  logic [7:0] b; // byte being gathered
  int bad_stop; // frames with a low stop bit
  // sensor bus is host's, not modelled
  initial begin
    to_dev = 1'h1;
    bad_stop = 0;
  end

  // frame out, lsb first, idle high
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'h0};
    for (int i = 0; i < 10; i++) begin
      to_dev = f[i];
      repeat (BIT) @(negedge clk);
    end
    to_dev = 1'h1;
  endtask

  always begin
    @(negedge from_dev);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = from_dev;
    end
    repeat (BIT) @(posedge clk);
    if (from_dev) begin
      got_q.push_back(b);
    end else begin
      bad_stop++;
    end
  end
endmodule
`default_nettype wire

// ---- bench/ghu_host_uart_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// testbench for the host serial port
// ------------------------------------------------------------
module ghu_host_uart_tb_top;
  localparam int BIT = 16; // short bit time
  localparam int MSC = 2; // cycles per ms tick
  logic clk = 1'h0;
  logic arst_n, rx_line, tx_line, nav_valid, nav_ready, fix_strobe;
  logic orbit_predicted, sat_data_poor, low_power, rx_strobe, frame_error;
  logic log_write, use_assist;
  logic [7:0] nav_data, rx_data;
  logic [1:0] motion_level;
  ghu_pkg::ghu_fix_s fix_in;
  ghu_pkg::ghu_mode_e power_mode;
  ghu_pkg::ghu_log_s log_record;
  int fails = 0;
  int num_checks = 0;
  int n_rx = 0, n_fe = 0;

  always #2 clk = ~clk;

  ghu_host_uart #(.BIT_CYCLES(BIT), .MS_CYCLES(MSC), .ASSIST_LIMIT_MS(32'h0000_0032)) DUT (
    .clk(clk), .arst_n(arst_n), .serial_in_line(rx_line), .serial_out_line(tx_line),
    .nav_data(nav_data), .nav_valid(nav_valid), .nav_ready(nav_ready),
    .motion_level(motion_level), .fix_in(fix_in), .fix_strobe(fix_strobe),
    .orbit_predicted(orbit_predicted), .sat_data_poor(sat_data_poor),
    .power_mode(power_mode), .low_power(low_power), .rx_data(rx_data),
    .rx_strobe(rx_strobe), .frame_error(frame_error), .log_record(log_record),
    .log_write(log_write), .use_assist(use_assist));

  ghu_host_model #(.BIT(BIT)) host (.clk(clk), .to_dev(rx_line), .from_dev(tx_line));

  // count receive results
  always @(negedge clk) begin
    if (rx_strobe === 1'h1) n_rx++;
    if (frame_error === 1'h1) n_fe++;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  function automatic logic in_win(input int n, input int e);
    return (n >= e - 30) && (n <= e + 30);
  endfunction

  // dollar, letter, star, checksum, cr lf
  task send_cmd(input logic [7:0] l);
    host.send(ghu_pkg::CH_DOLLAR, 1'h1);
    host.send(l, 1'h1);
    host.send(ghu_pkg::CH_STAR, 1'h1);
    host.send(hexc(l[7:4]), 1'h1);
    host.send(hexc(l[3:0]), 1'h1);
    host.send(ghu_pkg::CH_CR, 1'h1);
    host.send(ghu_pkg::CH_LF, 1'h1);
    repeat (3) @(negedge clk);
  endtask

  task wait_lp(input logic lvl, output int n);
    n = 0;
    while (low_power !== lvl && n < 30000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // good byte then a byte with low stop bit
  task t_rx;
    int n;
    n = n_rx;
    host.send(8'ha5, 1'h1);
    chk(n_rx, n + 1);
    chk(rx_data, 8'ha5);
    n = n_fe;
    host.send(8'h3c, 1'h0);
    repeat (BIT) @(negedge clk);
    chk(n_fe, n + 1);
    chk(rx_data, 8'ha5);
  endtask

  // standby holds transmit, buffer fills, a good byte wakes
  task t_standby;
    int n;
    host.got_q.delete();
    send_cmd(ghu_pkg::CMD_STANDBY);
    chk(power_mode, ghu_pkg::MODE_STANDBY);
    n = 0;
    while (n < 40) begin
      @(negedge clk);
      if (nav_ready !== 1'h1) break;
      nav_data = 8'(n);
      nav_valid = 1'h1;
      n++;
    end
    nav_valid = 1'h0;
    chk(n >= 16 && n <= 17, 1'h1);
    chk(host.got_q.size(), 0);
    host.send(8'h00, 1'h1);
    chk(power_mode, ghu_pkg::MODE_NORMAL);
    repeat ((n + 1) * 10 * BIT) @(negedge clk);
    chk(host.got_q.size(), n);
    for (int i = 0; i < n && i < host.got_q.size(); i++) chk(host.got_q[i], i);
  endtask

  // periodic run and sleep lengths
  task t_periodic;
    int n;
    send_cmd(ghu_pkg::CMD_PERIODIC);
    chk(power_mode, ghu_pkg::MODE_PERIODIC);
    wait_lp(1'h1, n);
    chk(in_win(n, int'(ghu_pkg::PER_RUN_MS) * MSC), 1'h1);
    wait_lp(1'h0, n);
    chk(in_win(n, int'(ghu_pkg::PER_SLEEP_MS) * MSC), 1'h1);
    send_cmd(ghu_pkg::CMD_NORMAL);
    chk(power_mode, ghu_pkg::MODE_NORMAL);
  endtask

  // adaptive intervals follow motion, command taken while asleep
  task t_adaptive;
    int n;
    motion_level = 2'h3;
    send_cmd(ghu_pkg::CMD_ADAPTIVE);
    chk(power_mode, ghu_pkg::MODE_ADAPTIVE);
    wait_lp(1'h1, n);
    chk(in_win(n, int'(ghu_pkg::ADP_RUN_MS << 3) * MSC), 1'h1);
    wait_lp(1'h0, n);
    chk(in_win(n, int'(ghu_pkg::ADP_SLEEP_MS >> 3) * MSC), 1'h1);
    wait_lp(1'h1, n);
    send_cmd(ghu_pkg::CMD_NORMAL);
    chk(power_mode, ghu_pkg::MODE_NORMAL);
    chk(low_power, 1'h0);
  endtask

  // logger record and checksum
  task t_log;
    logic [96:0] f;
    logic [7:0] cs;
    f = {32'h0102_0304, 32'h1122_3344, 32'ha5a5_0ff0, 1'h1};
    cs = {7'h0, f[0]};
    for (int i = 0; i < 12; i++) cs ^= f[1 + i * 8 +: 8];
    fix_in = f;
    fix_strobe = 1'h1;
    @(negedge clk);
    fix_strobe = 1'h0;
    chk(log_write, 1'h1);
    chk(log_record.fix === fix_in, 1'h1);
    chk(log_record.csum, cs);
    @(negedge clk);
    chk(log_write, 1'h0);
  endtask

  // assist use ends past the horizon
  task t_assist;
    sat_data_poor = 1'h1;
    orbit_predicted = 1'h1;
    @(negedge clk);
    orbit_predicted = 1'h0;
    repeat (10) @(negedge clk);
    chk(use_assist, 1'h1);
    sat_data_poor = 1'h0;
    @(negedge clk);
    chk(use_assist, 1'h0);
    sat_data_poor = 1'h1;
    repeat (100) @(negedge clk);
    chk(use_assist, 1'h0);
  endtask

  // main sequence
  initial begin
    arst_n = 1'h0;
    nav_data = 8'h00;
    nav_valid = 1'h0;
    motion_level = 2'h0;
    fix_in = '0;
    fix_strobe = 1'h0;
    orbit_predicted = 1'h0;
    sat_data_poor = 1'h1;
    repeat (3) @(negedge clk);
    chk(tx_line, 1'h1);
    chk(power_mode, ghu_pkg::MODE_NORMAL);
    chk(use_assist, 1'h0);
    arst_n = 1'h1;
    t_rx();
    t_standby();
    t_periodic();
    t_adaptive();
    t_log();
    t_assist();
    chk(host.bad_stop, 0);
    final_report();
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
